// ===== ltsc_pkg.sv
/*
  Constants for the low power amplifier loop switch and control registers.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
// What this block does
// - Switch register bits 0 to 13 drive loop switches 0 to 13, one closes.
// - Bit 15 drives recalibration switch; bit 14 reserved but read/write.
// - Switch register decoded at 0x20e4, resets to zero, all switches open.
// - Control register decoded at 0x20ec, resets to three.
// - Control bits 15:13 select filter resistor and cutoff, reset zero.
// - Filter code zero disconnects amp output from filter pin and capacitor.
// - Filter codes 1..6 select bypass, 20k, 100k, 200k, 400k, 600k.
// - Filter code 7 selects 1 Mohm, lowest cutoff.
// - Control bits 12:10 select load resistor, codes 0..7, reset zero.
// - Control bits 9:5 select gain resistor; zero disconnects it; reset zero.
package ltsc_pkg;
  localparam int ltsc_addr_w = 16;
  localparam logic [15:0] ltsc_sw_off = 16'h20e4;
  localparam logic [15:0] ltsc_con_off = 16'h20ec;
  localparam logic [15:0] ltsc_sw_rst = 16'h0000;
  localparam logic [15:0] ltsc_con_rst = 16'h0003;
  localparam int ltsc_rf_lsb = 13;
  localparam int ltsc_rl_lsb = 10;
  localparam int ltsc_gain_lsb = 5;
  localparam int ltsc_loop_sw_n = 14;
  localparam int ltsc_recalibration_switch_bit = 15;
  localparam logic [2:0] ltsc_rf_open = 3'h0;
  localparam logic [1:0] ltsc_resp_okay = 2'h0;
  localparam logic [1:0] ltsc_resp_slverr = 2'h2;
  localparam logic [4:0] ltsc_gain_open = 5'h00;
endpackage

// ===== ltsc_reg16.sv
/*
  One 16-bit software register with byte-lane write and a reset value.
  Assumes the bus logic pulses the write enable for one cycle.
*/
`timescale 1ns/10ps
module ltsc_reg16 #(
  parameter logic [15:0] rst_val = 16'h0000
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic wr_in,
  input wire logic [1:0] strb_in,
  input wire logic [15:0] data_in,
  output logic [15:0] q_out
);
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      q_out <= rst_val;
    else if (wr_in)
    begin
      if (strb_in[0])
        q_out[7:0] <= data_in[7:0];
      if (strb_in[1])
        q_out[15:8] <= data_in[15:8];
    end
  end
endmodule

// ===== ltsc_decode.sv
/*
  Decodes the filter resistor code into one-hot selects and a disconnect.
  Assumes a registered code at its input; outputs are combinational.
*/
`timescale 1ns/10ps
module ltsc_decode (
  input wire logic [2:0] code_in,
  output logic [7:0] onehot_out,
  output logic disconnect_out
);
  always_comb
  begin
    onehot_out = 8'h00;
    onehot_out[code_in] = 1'b1;
    disconnect_out = (code_in == ltsc_pkg::ltsc_rf_open);
  end
endmodule

// ===== ltsc_regs.sv
/*
  Register bank for the low power amplifier loop: switch and control words.
  Assumes an AXI4-Lite master; outputs are static levels to analog section.
*/
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
module ltsc_regs (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [13:0] loop_switch_out,
  output logic recalibration_switch_loop_switch_out,
  output logic [7:0] filter_resistor_out,
  output logic filter_pin_disconnect_out,
  output logic [2:0] load_resistor_select_out,
  output logic [4:0] gain_resistor_select_out,
  output logic gain_resistor_disconnect_out
);
  logic [15:0] aw_reg;
  logic aw_have_reg;
  logic [31:0] w_reg;
  logic [3:0] ws_reg;
  logic w_have_reg;
  logic wr_go;
  logic wr_sw;
  logic wr_con;
  logic wr_ok;
  logic [15:0] sw_q;
  logic [15:0] con_q;
  logic [7:0] rf_onehot;
  logic rf_open;
  logic aw_have_next;
  logic w_have_next;
  logic bvalid_next;
  logic rvalid_next;

  //////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  // Next-state terms let the readies come from flops yet act as before
  assign aw_have_next = (s_axi_awvalid && s_axi_awready)
                        || (aw_have_reg && !wr_go);
  assign w_have_next = (s_axi_wvalid && s_axi_wready)
                       || (w_have_reg && !wr_go);
  assign bvalid_next = wr_go || (s_axi_bvalid && !s_axi_bready);
  assign rvalid_next = (s_axi_arvalid && s_axi_arready)
                       || (s_axi_rvalid && !s_axi_rready);

  // Readies registered so every port leaves a flop; idle value is high
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_arready <= 1'b1;
    end
    else
    begin
      s_axi_awready <= !aw_have_next && !bvalid_next;
      s_axi_wready <= !w_have_next && !bvalid_next;
      s_axi_arready <= !rvalid_next;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      aw_reg <= 16'h0000;
      aw_have_reg <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_reg <= s_axi_awaddr;
      aw_have_reg <= 1'b1;
    end
    else if (wr_go)
      aw_have_reg <= 1'b0;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      w_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
      w_have_reg <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_reg <= s_axi_wdata;
      ws_reg <= s_axi_wstrb;
      w_have_reg <= 1'b1;
    end
    else if (wr_go)
      w_have_reg <= 1'b0;
  end

  assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;

  // Low two address bits ignored; word aligned
  always_comb
  begin
    wr_sw = 1'b0;
    wr_con = 1'b0;
    if (aw_reg[15:2] == ltsc_pkg::ltsc_sw_off[15:2])
      wr_sw = wr_go;
    else if (aw_reg[15:2] == ltsc_pkg::ltsc_con_off[15:2])
      wr_con = wr_go;
  end
  assign wr_ok = wr_sw || wr_con;

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ltsc_pkg::ltsc_resp_okay;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? ltsc_pkg::ltsc_resp_okay
                           : ltsc_pkg::ltsc_resp_slverr;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Storage: only the low half exists, upper lanes are dropped
  ltsc_reg16 #(
    .rst_val(ltsc_pkg::ltsc_sw_rst)
  ) u_sw (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .wr_in(wr_sw),
    .strb_in(ws_reg[1:0]),
    .data_in(w_reg[15:0]),
    .q_out(sw_q)
  );

  ltsc_reg16 #(
    .rst_val(ltsc_pkg::ltsc_con_rst)
  ) u_con (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .wr_in(wr_con),
    .strb_in(ws_reg[1:0]),
    .data_in(w_reg[15:0]),
    .q_out(con_q)
  );

  //////////////////////////////////////////////////////////////////////////
  // Read channel: one beat, answer the cycle after the address is taken
  // Address ready is held low while a read answer waits for rready

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ltsc_pkg::ltsc_resp_okay;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr[15:2] == ltsc_pkg::ltsc_sw_off[15:2])
      begin
        s_axi_rdata <= {16'h0000, sw_q};
        s_axi_rresp <= ltsc_pkg::ltsc_resp_okay;
      end
      else if (s_axi_araddr[15:2] == ltsc_pkg::ltsc_con_off[15:2])
      begin
        s_axi_rdata <= {16'h0000, con_q};
        s_axi_rresp <= ltsc_pkg::ltsc_resp_okay;
      end
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= ltsc_pkg::ltsc_resp_slverr;
      end
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Analog-facing levels, registered so they never glitch
  ltsc_decode u_rf (
    .code_in(con_q[ltsc_pkg::ltsc_rf_lsb +: 3]),
    .onehot_out(rf_onehot),
    .disconnect_out(rf_open)
  );

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      loop_switch_out <= 14'h0000;
      recalibration_switch_loop_switch_out <= 1'b0;
    end
    else
    begin
      loop_switch_out <= sw_q[ltsc_pkg::ltsc_loop_sw_n-1:0];
      recalibration_switch_loop_switch_out <= sw_q[ltsc_pkg::ltsc_recalibration_switch_bit];
    end
  end

  // Reset levels match a control word of three: filter open, gain open
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      filter_resistor_out <= 8'h01;
      filter_pin_disconnect_out <= 1'b1;
      load_resistor_select_out <= 3'h0;
      gain_resistor_select_out <= 5'h00;
      gain_resistor_disconnect_out <= 1'b1;
    end
    else
    begin
      filter_resistor_out <= rf_onehot;
      filter_pin_disconnect_out <= rf_open;
      load_resistor_select_out <= con_q[ltsc_pkg::ltsc_rl_lsb +: 3];
      gain_resistor_select_out <= con_q[ltsc_pkg::ltsc_gain_lsb +: 5];
      gain_resistor_disconnect_out <=
        (con_q[ltsc_pkg::ltsc_gain_lsb +: 5] == ltsc_pkg::ltsc_gain_open);
    end
  end
endmodule

// ===== ltsc_regs_monitor.sv
/* Port assertions for ltsc_regs; bound into every instance of it. */
`timescale 1ns/10ps
module ltsc_regs_monitor (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [13:0] loop_switch_out,
  input wire logic [7:0] filter_resistor_out,
  input wire logic filter_pin_disconnect_out,
  input wire logic [4:0] gain_resistor_select_out,
  input wire logic gain_resistor_disconnect_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_sel; $onehot(filter_resistor_out); endproperty
  a_sel: assert property (p_sel) else $error("sel");
  property p_fd; filter_pin_disconnect_out == filter_resistor_out[0];
  endproperty
  a_fd: assert property (p_fd) else $error("fd");
  property p_gd; gain_resistor_disconnect_out == !gain_resistor_select_out;
  endproperty
  a_gd: assert property (p_gd) else $error("gd");
  property p_rz; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_rz: assert property (p_rz) else $error("rz");
  // Analog levels move only one edge after a write response
  property p_sw; $changed(loop_switch_out) |-> $past(s_axi_bvalid);
  endproperty
  a_sw: assert property (p_sw) else $error("sw");
  property p_fc; $changed(filter_resistor_out) |-> $past(s_axi_bvalid);
  endproperty
  a_fc: assert property (p_fc) else $error("fc");
  property p_gc; $changed(gain_resistor_select_out) |-> $past(s_axi_bvalid);
  endproperty
  a_gc: assert property (p_gc) else $error("gc");
  property p_rs;
    $rose(rst_b_in) |-> !loop_switch_out && filter_resistor_out == 8'h01;
  endproperty
  a_rs: assert property (p_rs) else $error("rs");
  c_wr: cover property (s_axi_bvalid);
  c_rd: cover property (s_axi_rvalid);
  c_lp: cover property (filter_resistor_out[7]);
endmodule
bind ltsc_regs ltsc_regs_monitor i_mon (.*);

// ===== ltsc_host.sv
/* Bus host model: AXI4-Lite master, one access at a time via acc. */
`timescale 1ns/10ps
module ltsc_host (
  input wire logic core_clk_in,
  output logic [15:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [15:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  bit hung;
  initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
  initial {s_axi_arvalid, s_axi_rready} = 2'h0;
  initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  task automatic acc(input bit w, input logic [15:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] q, output logic [1:0] r);
    int n = 0;
    @(posedge core_clk_in);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    do
    begin
      @(posedge core_clk_in);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 50);
    {q, r} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
    {s_axi_bready, s_axi_rready} <= 2'h0;
    hung |= n >= 50;
  endtask
endmodule

// ===== tb_top.sv
/* Top bench: random and corner register traffic with output checks. */
`timescale 1ns/10ps
module tb_top;
  logic core_clk_in, rst_b_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, recalibration_switch_loop_switch_out;
  logic filter_pin_disconnect_out, gain_resistor_disconnect_out;
  logic [15:0] s_axi_awaddr, s_axi_araddr, cw, sw;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [3:0] s_axi_wstrb;
  logic [13:0] loop_switch_out;
  logic [7:0] filter_resistor_out;
  logic [2:0] load_resistor_select_out;
  logic [4:0] gain_resistor_select_out;
  int err_count, n_checks;
  ltsc_regs i_dut (.*);
  ltsc_host i_host (.*);
  initial forever #5 core_clk_in = ~core_clk_in;
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, g, input string nm);
    n_checks++;
    if (g !== e || i_host.hung)
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    err_count += (g !== e || i_host.hung);
    if (i_host.hung)
      end_of_test;
  endtask
  task automatic acc(input bit w, input logic [15:0] a, input logic [31:0] d,
    e, input logic [3:0] s, input logic [1:0] er);
    i_host.acc(w, a, d, s, rv, rs);
    if (!w)
      chk(e, rv, "rdata");
    chk({30'h0, er}, {30'h0, rs}, "resp");
  endtask
  function automatic logic [8:0] fx(input logic [2:0] c);
    return {8'h01 << c, c == 3'h0};
  endfunction
  task automatic out(input logic [15:0] s, c);
    chk({s[15], s[13:0], c[12:5], !c[9:5]}, {recalibration_switch_loop_switch_out,
      loop_switch_out, load_resistor_select_out, gain_resistor_select_out,
      gain_resistor_disconnect_out}, "switch load gain");
    chk(fx(c[15:13]), {filter_resistor_out, filter_pin_disconnect_out},
      "filter");
  endtask
  initial
  begin
    {core_clk_in, rst_b_in} = 2'b00;
    void'($urandom(32'hb404));
    repeat (2) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    acc(0, 16'h20e4, 0, 0, 0, 0);
    acc(0, 16'h20ec, 0, 3, 0, 0);
    out(0, 3);
    $display("test reset done");
    for (int c = 0; c < 8; c++)
    begin
      {sw, cw} = $urandom;
      cw[15:13] = c[2:0];
      cw[9:5] &= {5{c[0]}};
      acc(1, 16'h20ec, {~cw, cw}, 0, 4'hf, 0);
      acc(1, 16'h20e4, {~sw, sw}, 0, 4'hf, 0);
      acc(0, 16'h20ec, 0, cw, 0, 0);
      acc(0, 16'h20e4, 0, sw, 0, 0);
      out(sw, cw);
    end
    $display("test codes done");
    acc(1, 16'h20e8, '1, 0, 4'hf, 2);
    acc(0, 16'h20e8, 0, 0, 0, 2);
    acc(1, 16'h20e4, '1, 0, 4'h2, 0);
    sw[15:8] = 8'hff;
    acc(0, 16'h20e4, 0, sw, 0, 0);
    out(sw, cw);
    $display("test strobe done");
    end_of_test;
  end
endmodule
